//--- rtl/vof_pkg.sv
// ****************************************************************
// Shared constants of the video output formatter.
// ****************************************************************
package vof_pkg;

   // ****************************************************************
   // Register indices; the byte address is four times the index.
   // ****************************************************************
   localparam logic [7:0] IDX_OUT_CTRL = 8'h03; // Width and scaled-line control.
   localparam logic [7:0] IDX_AUX_CTRL = 8'h19; // Blanking capture and pin select.
   localparam logic [7:0] IDX_HSTART = 8'h07; // Horizontal start count.
   localparam logic [7:0] IDX_HLEN = 8'h08; // Horizontal window length.
   localparam logic [7:0] IDX_VSTART = 8'h09; // Vertical start count.
   localparam logic [7:0] IDX_VLEN = 8'h0A; // Vertical window length.
   localparam logic [7:0] IDX_HSWIDTH = 8'h0B; // Horizontal sync width.
   localparam logic [7:0] IDX_BLANK_LINE = 8'h0C; // First blanking capture line.
   localparam logic [7:0] IDX_STATUS = 8'h0D; // Live flags and line count.

   // ****************************************************************
   // Field positions inside the control registers.
   // ****************************************************************
   localparam int BIT_WIDE = 6; // Output width select in the output control.
   localparam int BIT_SCALED_EN = 3; // Scaled-line horizontal enable.
   localparam int BIT_BLANK_CAP = 7; // Blanking capture enable.
   localparam int BIT_BLANK_HEN = 4; // Blank-line horizontal enable.
   localparam int SEL_LSB = 0; // Low bit of the aux pin source select.
   localparam int SEL_W = 3; // Width of the aux pin source select.
   localparam logic [2:0] SEL_KEPT_LINE = 3'h7; // Select value for the kept-line flag.

   // ****************************************************************
   // Reset values and fixed figures.
   // ****************************************************************
   localparam logic [7:0] OUT_CTRL_RST = 8'h00; // Narrow output, scaled lines off.
   localparam logic [7:0] AUX_CTRL_RST = 8'h00; // Capture off, pin select zero.
   localparam logic [11:0] HSTART_RST = 12'h020; // Default horizontal start.
   localparam logic [11:0] HLEN_RST = 12'h2D0; // Default window of 720 pixels.
   localparam logic [9:0] VSTART_RST = 10'h014; // Default vertical start.
   localparam logic [9:0] VLEN_RST = 10'h0F0; // Default window of 240 lines.
   localparam logic [7:0] HSWIDTH_RST = 8'h40; // Default sync width in half-rate cycles.
   localparam logic [9:0] BLANK_LINE_RST = 10'h00A; // Default first blanking line.
   localparam logic [7:0] HSWIDTH_MIN = 8'h08; // Narrowest sync width served.
   localparam logic [7:0] HSWIDTH_MAX = 8'h80; // Widest sync width served.
   localparam logic [6:0] VS_TERM_CYC = 7'h40; // Double-rate cycles to end vertical sync.
   localparam logic [7:0] Y_BLANK = 8'h10; // Luma value outside the window.
   localparam logic [7:0] C_BLANK = 8'h80; // Chroma value outside the window.
   localparam logic [1:0] ALIGN_OK = 2'h0; // Low address bits of an aligned word.

endpackage : vof_pkg

//--- rtl/vof_formatter.sv
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Width bit picks 8 or 16 bits.
// - All outputs launch on double-rate rising edge.
// - Narrow mode order Cb, Y, Cr, Y.
// - Wide mode luma high, chroma low, word.
// - Reset gives narrow stream, separate syncs.
// - Sync and flag timing independent of width.
// - Sync width programmable, leading edge follows input.
// - Vertical sync leading edge follows input.
// - Odd field ends 64 after sync trailing.
// - Even field ends 64 after sync leading.
// - Field flag updates at vertical sync start.
// - Unknown parity makes field flag toggle.
// - Horizontal sync changes only on half-rate rise.
// - Capture lines carry blanking window waveform.
// - Select value seven routes kept-line flag out.
// - Blank lines need blank-line enable for window.
// - Dropped scaled lines need scaled-line enable.
// - Blanking waveform wins on capture lines.
// - Window starts at start count, lasts length.
// - Horizontal window changes only on half-rate rise.
// - Sync-to-window delay constant on active lines.
// - Half-rate clock is exactly half frequency.
// - Vertical window from start count, changes at sync.
// - Capture lines kept from blanking start line.
module vof_formatter #(
   parameter int HCNT_W = 12, // Width of the per-line half-rate counter.
   parameter int LINE_W = 10 // Width of the per-field line counter.
) (
   input wire logic pclk, // Double-rate pixel clock.
   input wire logic presetn, // Asynchronous reset, active low.
   input wire logic psel, // APB select.
   input wire logic penable, // APB access phase.
   input wire logic pwrite, // APB write direction.
   input wire logic [11:0] paddr, // APB byte address.
   input wire logic [31:0] pwdata, // APB write data.
   output logic [31:0] prdata, // APB read data.
   output logic pready, // APB ready.
   output logic pslverr, // APB error for unmapped or unaligned.
   input wire logic src_line_start, // Pulse: incoming line sync found.
   input wire logic src_vsync_start, // Pulse: first serration low found.
   input wire logic src_eq_end, // Pulse: last equalization pulse done.
   input wire logic src_field_odd, // Parity of the coming field.
   input wire logic src_field_known, // Parity decision is valid.
   input wire logic src_line_kept, // Vertical scaler keeps this line.
   input wire logic [7:0] src_y, // Luma of the current pixel.
   input wire logic [7:0] src_c, // Chroma of the current pixel.
   input wire logic src_c_is_cb, // Current chroma is blue difference.
   output logic [15:0] video_pixel_bus, // Pixel data lanes.
   output logic pixel_clock_half, // Half-rate clock.
   output logic hsync_out, // Horizontal sync, active high.
   output logic vsync_out, // Vertical sync, active high.
   output logic field_out, // High during an odd field.
   output logic horiz_window_flag, // Horizontal active window.
   output logic vert_window_flag, // Vertical active window.
   output logic kept_line_flag, // Line valid flag.
   output logic multipurpose_pin, // Selected auxiliary signal.
   output logic blue_chroma_marker // High while window chroma is blue difference.
);

   // ****************************************************************
   // State of the block, held in one record.
   // ****************************************************************
   typedef struct packed {
      logic [7:0] out_ctrl; // Output control register.
      logic [7:0] aux_ctrl; // Auxiliary control register.
      logic [11:0] hstart; // Horizontal start count.
      logic [11:0] hlen; // Horizontal window length.
      logic [9:0] vstart; // Vertical start count.
      logic [9:0] vlen; // Vertical window length.
      logic [7:0] hswidth; // Horizontal sync width.
      logic [9:0] blank_line; // First blanking capture line.
      logic [31:0] rdata; // Read data held for the access phase.
      logic ready; // Ready for the access phase.
      logic err; // Error for the access phase.
      logic ph; // Half-rate clock phase.
      logic pend_h; // Line start waiting for the next half-rate rise.
      logic [HCNT_W-1:0] hcnt; // Half-rate cycles since sync leading edge.
      logic hsync; // Horizontal sync level.
      logic hwin; // Raw horizontal window.
      logic hact; // Gated horizontal window.
      logic line_gate; // Window allowed on the current line.
      logic vsync; // Vertical sync level.
      logic term_arm; // Last equalization seen.
      logic term_wait; // Odd field waits for sync trailing edge.
      logic term_run; // Termination count running.
      logic [6:0] term_cnt; // Termination count.
      logic field; // Field flag.
      logic [LINE_W-1:0] line; // Line count inside the field.
      logic vact; // Vertical window.
      logic [LINE_W-1:0] vcnt; // Lines left in the vertical window.
      logic kept; // Line valid flag.
      logic [7:0] y_hold; // Luma waiting for its narrow slot.
      logic [15:0] bus; // Pixel lanes.
      logic cbmark; // Blue chroma marker.
      logic mp; // Auxiliary pin.
   } vof_state_t;

   vof_state_t st_r; // Registered state.
   vof_state_t st_nxt; // Next state.

   // ****************************************************************
   // Parameter checks.
   // ****************************************************************
   if (HCNT_W < 12 || LINE_W < 10) begin : g_check
      $error("vof_formatter: counter widths too narrow");
   end

   // ****************************************************************
   // Next-state logic.
   // ****************************************************************
   // One process fills the whole next state from the current one.
   always_comb begin
      logic [7:0] idx;
      logic [HCNT_W-1:0] hn;
      logic rise, lead, trail, vact_n, kept_n, mapped;
      idx = paddr[9:2];
      rise = 1'b0;
      lead = 1'b0;
      hn = '0;
      trail = 1'b0;
      vact_n = 1'b0;
      kept_n = 1'b0;
      mapped = 1'b0;
      st_nxt = st_r;

      // Register bus: decode at setup, answer in the access cycle.
      mapped = (paddr[1:0] == vof_pkg::ALIGN_OK) && (paddr[11:10] == 2'h0) &&
         (idx inside {vof_pkg::IDX_OUT_CTRL, vof_pkg::IDX_AUX_CTRL, vof_pkg::IDX_HSTART,
          vof_pkg::IDX_HLEN, vof_pkg::IDX_VSTART, vof_pkg::IDX_VLEN, vof_pkg::IDX_HSWIDTH,
          vof_pkg::IDX_BLANK_LINE, vof_pkg::IDX_STATUS});
      st_nxt.ready = psel && !penable;
      st_nxt.err = psel && !penable && !mapped;
      if (psel && !penable) begin
         case (idx)
            vof_pkg::IDX_OUT_CTRL: st_nxt.rdata = 32'(st_r.out_ctrl);
            vof_pkg::IDX_AUX_CTRL: st_nxt.rdata = 32'(st_r.aux_ctrl);
            vof_pkg::IDX_HSTART: st_nxt.rdata = 32'(st_r.hstart);
            vof_pkg::IDX_HLEN: st_nxt.rdata = 32'(st_r.hlen);
            vof_pkg::IDX_VSTART: st_nxt.rdata = 32'(st_r.vstart);
            vof_pkg::IDX_VLEN: st_nxt.rdata = 32'(st_r.vlen);
            vof_pkg::IDX_HSWIDTH: st_nxt.rdata = 32'(st_r.hswidth);
            vof_pkg::IDX_BLANK_LINE: st_nxt.rdata = 32'(st_r.blank_line);
            // Status shows field, syncs, windows and the line count.
            vof_pkg::IDX_STATUS: st_nxt.rdata = {10'h000, st_r.field, st_r.vsync,
               st_r.hsync, st_r.vact, st_r.kept, st_r.hact,
               {(16 - LINE_W){1'b0}}, st_r.line};
            default: st_nxt.rdata = 32'h0000_0000;
         endcase
         if (!mapped) begin
            st_nxt.rdata = 32'h0000_0000;
         end
      end
      // Writes land in the access cycle of a mapped, aligned word.
      if (psel && penable && pwrite && !st_r.err) begin
         case (idx)
            vof_pkg::IDX_OUT_CTRL: st_nxt.out_ctrl = pwdata[7:0];
            vof_pkg::IDX_AUX_CTRL: st_nxt.aux_ctrl = pwdata[7:0];
            vof_pkg::IDX_HSTART: st_nxt.hstart = pwdata[11:0];
            vof_pkg::IDX_HLEN: st_nxt.hlen = pwdata[11:0];
            vof_pkg::IDX_VSTART: st_nxt.vstart = pwdata[9:0];
            vof_pkg::IDX_VLEN: st_nxt.vlen = pwdata[9:0];
            // Out-of-range widths are clamped so the counter stays served.
            vof_pkg::IDX_HSWIDTH: st_nxt.hswidth = (pwdata[7:0] < vof_pkg::HSWIDTH_MIN) ?
               vof_pkg::HSWIDTH_MIN : (|pwdata[31:8] || pwdata[7:0] > vof_pkg::HSWIDTH_MAX) ?
               vof_pkg::HSWIDTH_MAX : pwdata[7:0];
            vof_pkg::IDX_BLANK_LINE: st_nxt.blank_line = pwdata[9:0];
            default: begin
               // Status and unmapped words ignore writes.
            end
         endcase
      end

      // Half-rate clock: a toggle, so it is exactly half the rate.
      st_nxt.ph = !st_r.ph;
      rise = !st_r.ph;

      // A line start is held until the half-rate clock next goes high.
      if (src_line_start) begin
         st_nxt.pend_h = 1'b1;
      end
      lead = rise && st_r.pend_h;
      // The count saturates at its ceiling on very long lines.
      hn = lead ? '0 : ((&st_r.hcnt) ? st_r.hcnt : st_r.hcnt + 1'b1);

      // Horizontal sync and window move only on the half-rate rise.
      if (rise) begin
         st_nxt.hcnt = hn;
         if (lead) begin
            st_nxt.pend_h = src_line_start;
            st_nxt.hsync = 1'b1;
         end else if (st_r.hsync && hn == HCNT_W'(st_r.hswidth)) begin
            st_nxt.hsync = 1'b0;
            trail = 1'b1;
         end
         // Start is counted from the sync leading edge alone, so the delay
         // to the window is the same on every active line.
         if (hn == st_r.hstart) begin
            st_nxt.hwin = 1'b1;
         end else if (hn == HCNT_W'(st_r.hstart + st_r.hlen)) begin
            st_nxt.hwin = 1'b0;
         end
      end

      // Line events: count, vertical window and kept-line flag.
      vact_n = st_r.vact;
      kept_n = st_r.kept;
      if (lead) begin
         st_nxt.line = st_r.line + 1'b1;
         if (st_r.line == LINE_W'(st_r.vstart) && st_r.vlen != 10'h000) begin
            vact_n = 1'b1;
            st_nxt.vcnt = LINE_W'(st_r.vlen) - 1'b1;
         end else if (st_r.vact) begin
            if (st_r.vcnt == '0) begin
               vact_n = 1'b0;
            end else begin
               st_nxt.vcnt = st_r.vcnt - 1'b1;
            end
         end
         if (vact_n) begin
            kept_n = src_line_kept;
         end else begin
            kept_n = st_r.aux_ctrl[vof_pkg::BIT_BLANK_CAP] &&
               (st_r.line >= LINE_W'(st_r.blank_line));
         end
         st_nxt.vact = vact_n;
         st_nxt.kept = kept_n;
         // Choose whether this line carries a window at all.
         if (st_r.aux_ctrl[vof_pkg::BIT_BLANK_CAP] && kept_n && !vact_n) begin
            st_nxt.line_gate = 1'b1;
         end else if (!vact_n) begin
            st_nxt.line_gate = st_r.aux_ctrl[vof_pkg::BIT_BLANK_HEN];
         end else if (!kept_n) begin
            st_nxt.line_gate = st_r.out_ctrl[vof_pkg::BIT_SCALED_EN];
         end else begin
            st_nxt.line_gate = 1'b1;
         end
      end
      if (rise) begin
         st_nxt.hact = st_nxt.hwin && st_nxt.line_gate;
      end

      // Vertical sync start: new field, line count restarts.
      if (src_vsync_start) begin
         st_nxt.vsync = 1'b1;
         st_nxt.line = '0;
         st_nxt.term_arm = 1'b0;
         st_nxt.term_wait = 1'b0;
         st_nxt.term_run = 1'b0;
         if (src_field_known) begin
            st_nxt.field = src_field_odd;
         end else begin
            st_nxt.field = !st_r.field;
         end
      end else begin
         if (src_eq_end && st_r.vsync) begin
            st_nxt.term_arm = 1'b1;
         end
         // Odd field waits for the trailing edge; even counts from the leading.
         if (st_r.term_arm && lead) begin
            st_nxt.term_arm = 1'b0;
            if (st_r.field) begin
               st_nxt.term_wait = 1'b1;
            end else begin
               st_nxt.term_run = 1'b1;
               st_nxt.term_cnt = vof_pkg::VS_TERM_CYC - 1'b1;
            end
         end
         if (st_r.term_wait && trail) begin
            st_nxt.term_wait = 1'b0;
            st_nxt.term_run = 1'b1;
            st_nxt.term_cnt = vof_pkg::VS_TERM_CYC - 1'b1;
         end
         if (st_r.term_run) begin
            if (st_r.term_cnt == 7'h00) begin
               st_nxt.term_run = 1'b0;
               st_nxt.vsync = 1'b0;
            end else begin
               st_nxt.term_cnt = st_r.term_cnt - 1'b1;
            end
         end
      end

      // Pixel lanes: the width only changes the data, never the syncs.
      if (st_r.out_ctrl[vof_pkg::BIT_WIDE]) begin
         if (rise) begin
            if (st_nxt.hact) begin
               st_nxt.bus = {src_y, src_c};
               st_nxt.cbmark = src_c_is_cb;
            end else begin
               st_nxt.bus = {vof_pkg::Y_BLANK, vof_pkg::C_BLANK};
               st_nxt.cbmark = 1'b0;
            end
         end
      end else begin
         // Chroma on the rise, its luma one double-rate cycle later.
         if (rise) begin
            if (st_nxt.hact) begin
               st_nxt.bus = {src_c, 8'h00};
               st_nxt.y_hold = src_y;
               st_nxt.cbmark = src_c_is_cb;
            end else begin
               st_nxt.bus = {vof_pkg::C_BLANK, 8'h00};
               st_nxt.y_hold = vof_pkg::Y_BLANK;
               st_nxt.cbmark = 1'b0;
            end
         end else begin
            st_nxt.bus = {st_r.y_hold, 8'h00};
         end
      end

      // Auxiliary pin shows the kept-line flag when selected.
      st_nxt.mp = (st_r.aux_ctrl[vof_pkg::SEL_LSB +: vof_pkg::SEL_W] ==
         vof_pkg::SEL_KEPT_LINE) && st_nxt.kept;
   end

   // ****************************************************************
   // State register.
   // ****************************************************************
   // All outputs launch from here on the double-rate rising edge.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '{out_ctrl: vof_pkg::OUT_CTRL_RST, aux_ctrl: vof_pkg::AUX_CTRL_RST,
            hstart: vof_pkg::HSTART_RST, hlen: vof_pkg::HLEN_RST, vstart: vof_pkg::VSTART_RST,
            vlen: vof_pkg::VLEN_RST, hswidth: vof_pkg::HSWIDTH_RST,
            blank_line: vof_pkg::BLANK_LINE_RST, y_hold: vof_pkg::Y_BLANK,
            bus: {vof_pkg::C_BLANK, 8'h00}, default: '0};
      end else begin
         st_r <= st_nxt;
      end
   end

   // ****************************************************************
   // Outputs, each straight from the state register.
   // ****************************************************************
   assign prdata = st_r.rdata;
   assign pready = st_r.ready;
   assign pslverr = st_r.err;
   assign video_pixel_bus = st_r.bus;
   assign pixel_clock_half = st_r.ph;
   assign hsync_out = st_r.hsync;
   assign vsync_out = st_r.vsync;
   assign field_out = st_r.field;
   assign horiz_window_flag = st_r.hact;
   assign vert_window_flag = st_r.vact;
   assign kept_line_flag = st_r.kept;
   assign multipurpose_pin = st_r.mp;
   assign blue_chroma_marker = st_r.cbmark;

endmodule : vof_formatter

`default_nettype wire

//--- dv/vof_formatter_props.sv
`timescale 1ns/1ps
`default_nettype none
// Output timing relations of the formatter, watched at its ports.
module vof_props (
   input wire logic pclk, // Double-rate clock.
   input wire logic presetn, // Reset, active low.
   input wire logic src_line_start, // Incoming line sync pulse.
   input wire logic src_vsync_start, // Incoming vertical sync pulse.
   input wire logic [15:0] video_pixel_bus, // Pixel lanes.
   input wire logic pixel_clock_half, // Half-rate clock.
   input wire logic hsync_out, // Horizontal sync.
   input wire logic vsync_out, // Vertical sync.
   input wire logic field_out, // Field flag.
   input wire logic horiz_window_flag // Horizontal window.
);
   logic [8:0] hs_len; // Cycles for which horizontal sync has been high.
   default clocking dc @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Counts the cycles of each horizontal sync pulse.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hs_len <= 9'h0;
      end else begin
         hs_len <= hsync_out ? hs_len + 9'h1 : 9'h0;
      end
   end
   property p_half_rate; $past(presetn) |-> pixel_clock_half != $past(pixel_clock_half); endproperty
   a_half_rate: assert property (p_half_rate) else $error("half clock");
   property p_hs_edge; $changed(hsync_out) |-> $rose(pixel_clock_half); endproperty
   a_hs_edge: assert property (p_hs_edge) else $error("hsync edge");
   property p_win_edge; $changed(horiz_window_flag) |-> $rose(pixel_clock_half); endproperty
   a_win_edge: assert property (p_win_edge) else $error("window edge");
   property p_hs_width; $fell(hsync_out) |-> hs_len == {vof_pkg::HSWIDTH_RST, 1'h0}; endproperty
   a_hs_width: assert property (p_hs_width) else $error("hsync width");
   property p_hs_lead; src_line_start |-> ##[1:3] $rose(hsync_out); endproperty
   a_hs_lead: assert property (p_hs_lead) else $error("hsync lead");
   property p_vs_lead; src_vsync_start |=> vsync_out; endproperty
   a_vs_lead: assert property (p_vs_lead) else $error("vsync lead");
   property p_field; $changed(field_out) |-> $rose(vsync_out); endproperty
   a_field: assert property (p_field) else $error("field edge");
   property p_wide; horiz_window_flag && $changed(video_pixel_bus[7:0]) |-> $rose(pixel_clock_half);
   endproperty
   a_wide: assert property (p_wide) else $error("chroma edge");
endmodule : vof_props
bind vof_formatter vof_props vof_props_i (.pclk(pclk), .presetn(presetn),
   .src_line_start(src_line_start), .src_vsync_start(src_vsync_start),
   .video_pixel_bus(video_pixel_bus), .pixel_clock_half(pixel_clock_half),
   .hsync_out(hsync_out), .vsync_out(vsync_out), .field_out(field_out),
   .horiz_window_flag(horiz_window_flag));
`default_nettype wire

//--- dv/vof_capture.sv
`timescale 1ns/1ps
`default_nettype none
// Capture device: times each line and checks pixel bytes.
module vof_capture (
   input wire logic pclk, // Double-rate clock.
   input wire logic wide, // Receiver set for the 16-bit stream.
   input wire logic [15:0] video_pixel_bus, // Pixel lanes.
   input wire logic pixel_clock_half, // Half-rate clock.
   input wire logic hsync_out, // Horizontal sync.
   input wire logic vsync_out, // Vertical sync.
   input wire logic horiz_window_flag, // Horizontal window.
   input wire logic blue_chroma_marker, // High for blue chroma.
   output logic got_win, // A window ended on this line.
   output logic [15:0] hs_to_win, // Cycles from sync to window.
   output logic [15:0] win_len, // Window length in cycles.
   output logic [15:0] hs_to_vf, // Sync to vertical sync end.
   output logic [15:0] bad_bytes // Pixel bytes out of place.
);
   logic hs_q = 1'h0, vs_q = 1'h0, win_q = 1'h0; // Previous samples.
   logic [15:0] cnt = 16'h0; // Cycles since the last sync leading edge.
   logic [15:0] exp; // Expected lanes for this sample.
   initial got_win = 1'h0;
   initial bad_bytes = 16'h0;
   // Narrow: chroma after each rise, luma one cycle later; wide: both together.
   always_comb exp = wide ? {8'h5A, blue_chroma_marker ? 8'hC1 : 8'h3E}
      : (pixel_clock_half ? {blue_chroma_marker ? 8'hC1 : 8'h3E, 8'h00} : 16'h5A00);
   // Samples each rising edge the way a capture register would.
   always @(posedge pclk) begin
      hs_q <= hsync_out;
      vs_q <= vsync_out;
      win_q <= horiz_window_flag;
      cnt <= (hsync_out && !hs_q) ? 16'h0 : cnt + 16'h1;
      if (hsync_out && !hs_q) got_win <= 1'h0;
      if (horiz_window_flag && !win_q) hs_to_win <= cnt + 16'h1;
      if (!horiz_window_flag && win_q) begin
         got_win <= 1'h1;
         win_len <= cnt + 16'h1 - hs_to_win;
      end
      if (!vsync_out && vs_q) hs_to_vf <= cnt + 16'h1;
      if (horiz_window_flag && video_pixel_bus !== exp) bad_bytes <= bad_bytes + 16'h1;
   end
endmodule : vof_capture
`default_nettype wire

//--- dv/test_video_output_sync_formatter.sv
`timescale 1ns/1ps
`default_nettype none
// APB setup, then three short fields in different modes.
module test_video_output_sync_formatter;
   localparam logic [7:0] AUX [3] = '{8'h00, 8'h87, 8'h10}; // Capture, pin select, blank enable.
   localparam logic [7:0] OUTC [3] = '{8'h00, 8'h48, 8'h00}; // Width and scaled-line enable.
   localparam logic [4:0] WMASK [3] = '{5'h04, 5'h1F, 5'h17}; // Lines that carry a window.
   localparam logic FEXP [3] = '{1'h1, 1'h0, 1'h1}; // Field flag after each vsync.
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic ls = 1'h0, vss = 1'h0, eqe = 1'h0, odd = 1'h0, known = 1'h1, lkept = 1'h1;
   logic cb = 1'h0, wide = 1'h0, rd_err, pready, pslverr, pch, hs, vs, fld, hwin, vwin, mp;
   logic mark, got_win, kept;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd_data;
   logic [7:0] cval = 8'h80;
   logic [15:0] bus, hs_to_win, win_len, hs_to_vf, bad_bytes;
   int fail_count = 0, samples_checked = 0, cycles = 0;
   always #25 pclk = ~pclk;
   vof_formatter vof_formatter_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .src_line_start(ls), .src_vsync_start(vss),
      .src_eq_end(eqe), .src_field_odd(odd), .src_field_known(known), .src_line_kept(lkept),
      .src_y(8'h5A), .src_c(cval), .src_c_is_cb(cb), .video_pixel_bus(bus),
      .pixel_clock_half(pch), .hsync_out(hs), .vsync_out(vs), .field_out(fld),
      .horiz_window_flag(hwin), .vert_window_flag(vwin), .kept_line_flag(kept),
      .multipurpose_pin(mp), .blue_chroma_marker(mark));
   vof_capture vof_capture_i (.pclk(pclk), .wide(wide), .video_pixel_bus(bus),
      .pixel_clock_half(pch), .hsync_out(hs), .vsync_out(vs), .horiz_window_flag(hwin),
      .blue_chroma_marker(mark), .got_win(got_win), .hs_to_win(hs_to_win),
      .win_len(win_len), .hs_to_vf(hs_to_vf), .bad_bytes(bad_bytes));
   // New pixel each half-rate period, chroma alternating blue and red.
   always @(posedge pclk) begin
      if (pch) begin
         cb <= !cb;
         cval <= cb ? 8'h3E : 8'hC1;
      end
   end
   // Cuts a hung run short.
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         complete_run();
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // One APB transfer; holds the request until pready is sampled high.
   task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      rd_data = prdata;
      rd_err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   // One incoming line of 302 cycles.
   task automatic line(input logic keep);
      @(posedge pclk);
      lkept <= keep;
      ls <= 1'h1;
      @(posedge pclk);
      ls <= 1'h0;
      repeat (300) @(posedge pclk);
   endtask : line
   task automatic complete_run();
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : complete_run
   // Sync width stays at 64 half cycles for odd-field endings.
   initial begin
      repeat (12) @(posedge pclk);
      check("reset_bus", bus, 16'h8000);
      presetn <= 1'h1;
      apb(1'h0, vof_pkg::IDX_OUT_CTRL, 32'h0);
      check("out_ctrl", rd_data, 32'h0);
      apb(1'h0, 8'h3F, 32'h0);
      check("unmapped", rd_err, 32'h1);
      apb(1'h1, vof_pkg::IDX_HSTART, 32'h10);
      apb(1'h1, vof_pkg::IDX_HLEN, 32'h20);
      apb(1'h1, vof_pkg::IDX_VSTART, 32'h2);
      apb(1'h1, vof_pkg::IDX_VLEN, 32'h2);
      apb(1'h1, vof_pkg::IDX_BLANK_LINE, 32'h0);
      apb(1'h0, vof_pkg::IDX_HSWIDTH, 32'h0);
      check("hswidth", rd_data, 32'h40);
      for (int f = 0; f < 3; f++) begin
         apb(1'h1, vof_pkg::IDX_AUX_CTRL, {24'h0, AUX[f]});
         apb(1'h1, vof_pkg::IDX_OUT_CTRL, {24'h0, OUTC[f]});
         wide <= OUTC[f][6];
         odd <= (f == 0);
         known <= (f != 2);
         @(posedge pclk);
         vss <= 1'h1;
         @(posedge pclk);
         vss <= 1'h0;
         @(posedge pclk);
         check("field", fld, FEXP[f]);
         for (int i = 1; i <= 5; i++) begin
            line(i != 4);
            if (i == 1) eqe <= 1'h1;
            @(posedge pclk);
            eqe <= 1'h0;
            check("window", got_win, WMASK[f][i-1]);
            if (got_win === 1'h1) begin
               check("hs_to_win", hs_to_win, 32'h20);
               check("win_len", win_len, 32'h40);
            end
            check("vact", vwin, i == 3 || i == 4);
            check("kept", kept, i == 3 || (AUX[f][7] && i != 4));
            check("aux_pin", mp, f == 1 && i != 4);
            if (i == 2) check("vs_end", hs_to_vf - (FEXP[f] ? 16'hC0 : 16'h40) <= 16'h3, 1);
         end
      end
      check("bad_bytes", bad_bytes, 32'h0);
      complete_run();
   end
endmodule : test_video_output_sync_formatter
`default_nettype wire
